// >>> design/rfs_pkg.sv
// ****************************************************************
// Shared constants of the switch driver serial port
// ****************************************************************
package rfs_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int unsigned FRAME_BITS     = 16;
  localparam int unsigned REG_BITS       = 8;
  localparam int unsigned CTRL_HI        = 15;
  localparam int unsigned CTRL_LO        = 8;
  localparam int unsigned STATE_HI       = 7;
  localparam int unsigned STATE_LO       = 0;

  // ****************************************************************
  // Control register bit positions
  // ****************************************************************
  localparam int unsigned CTL_WRITE_EN   = 7;
  localparam int unsigned CTL_FAULT      = 6;
  localparam int unsigned CTL_SLEEP      = 5;
  localparam int unsigned CTL_FLT_OFF    = 4;
  localparam int unsigned CTL_HVCMP_OFF  = 3;
  localparam int unsigned CTL_PUMP_ON    = 1;

  // ****************************************************************
  // Switch state register layout
  // ****************************************************************
  localparam int unsigned PATH_COUNT     = 4;

  // ****************************************************************
  // Values after reset
  // ****************************************************************
  localparam logic [7:0]  STATE_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [15:0] FRAME_RESET    = 16'h0000;

  // ****************************************************************
  // Interface select levels and serial clock limit
  // ****************************************************************
  localparam logic        MODE_SERIAL    = 1'b0;
  localparam real         SCK_MAX_MHZ    = 33.0;
  localparam real         REF_CLK_MHZ    = 25.0;
  // Serial clock needs a high and a low of at least two sampled cycles
  localparam int unsigned SCK_MIN_PERIOD_CYCLES = 4;

  // ****************************************************************
  // Transaction states, one-hot
  // ****************************************************************
  typedef enum logic [1:0] {
    RFS_IDLE  = 2'b01,
    RFS_SHIFT = 2'b10
  } rfs_state_type;

endpackage : rfs_pkg

// >>> design/rfs_serial_ctrl.sv
`timescale 1ns/1ns

module rfs_serial_ctrl
  import rfs_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Interface select pin
  input  wire logic mode_sel,
  // Serial port pins
  input  wire logic select_n,
  input  wire logic sck,
  input  wire logic mosi,
  output logic      miso,
  // Parallel-mode pins, ignored in serial mode
  input  wire logic pump_on_pin,
  input  wire logic fault_shutdown_pin,
  // Supply comparators, high while under voltage
  input  wire logic vdd_uv,
  input  wire logic hv_uv,
  // Switch drive
  output logic      path1_enable,
  output logic      path2_enable,
  output logic      path3_enable,
  output logic      path4_enable,
  // Analog control
  output logic      pump_enable,
  output logic      analog_enable,
  output logic      hv_comparator_enable,
  // Status
  output logic      fault_latched,
  output logic      shutdown_active,
  output logic [7:0] switch_path_state_out,
  output logic [7:0] driver_control_and_fault_out
);

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    logic [1:0]    mode_sync;
    logic [1:0]    sel_sync;
    logic [1:0]    sck_sync;
    logic [1:0]    mosi_sync;
    logic [1:0]    vdd_sync;
    logic [1:0]    hv_sync;
    logic [1:0]    pump_pin_sync;
    logic [1:0]    flt_pin_sync;
    logic          sel_prev;
    logic          sck_prev;
    rfs_state_type fsm;
    logic [15:0]   shreg;
    logic          miso;
    logic [7:0]    switch_path_state;
    logic [7:0]    driver_control_and_fault;
    logic          shutdown;
    logic [3:0]    paths;
    logic          pump;
    logic          analog;
    logic          hv_cmp;
  } rfs_regs_type;

  rfs_regs_type r;
  rfs_regs_type next_r;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Edge of a synchronised level against its previous sample
  function automatic logic rfs_rise(input logic now, input logic prev);
    rfs_rise = now & ~prev;
  endfunction : rfs_rise

  function automatic logic rfs_fall(input logic now, input logic prev);
    rfs_fall = ~now & prev;
  endfunction : rfs_fall

  // ****************************************************************
  // Synchronised views, second stage only
  // ****************************************************************
  logic serial_mode;
  logic sel_n_s;
  logic sck_s;
  logic mosi_s;
  logic vdd_uv_s;
  logic hv_uv_s;
  logic pump_pin_s;
  logic flt_pin_s;

  assign serial_mode = (r.mode_sync[1] == MODE_SERIAL);
  assign sel_n_s     = r.sel_sync[1];
  assign sck_s       = r.sck_sync[1];
  assign mosi_s      = r.mosi_sync[1];
  assign vdd_uv_s    = r.vdd_sync[1];
  assign hv_uv_s     = r.hv_sync[1];
  assign pump_pin_s  = r.pump_pin_sync[1];
  assign flt_pin_s   = r.flt_pin_sync[1];

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  logic sel_fall;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;

  // Parallel mode masks the port so stray pin levels start nothing
  assign sel_fall = serial_mode & rfs_fall(sel_n_s, r.sel_prev);
  assign sel_rise = rfs_rise(sel_n_s, r.sel_prev);
  assign sck_rise = rfs_rise(sck_s, r.sck_prev);
  assign sck_fall = rfs_fall(sck_s, r.sck_prev);

  // ****************************************************************
  // Effective control settings
  // ****************************************************************
  logic sleep_on;
  logic flt_off;
  logic hv_cmp_off;
  logic pump_req;
  logic fault_now;
  logic write_frame;

  // Register bits in serial mode, pins otherwise with sleep forced off; hv_cmp_off comes from the register in both modes
  always_comb begin
    sleep_on   = serial_mode & r.driver_control_and_fault[CTL_SLEEP];
    hv_cmp_off = r.driver_control_and_fault[CTL_HVCMP_OFF];
    if (serial_mode) begin
      flt_off  = r.driver_control_and_fault[CTL_FLT_OFF];
      pump_req = r.driver_control_and_fault[CTL_PUMP_ON];
    end else begin
      flt_off  = flt_pin_s;
      pump_req = pump_pin_s;
    end
  end

  // High-voltage comparator counts unless its control bit turns it off, sleep or not
  assign fault_now = vdd_uv_s | (hv_uv_s & ~hv_cmp_off);

  // Write enable travels in the frame's top bit
  assign write_frame = (r.fsm == RFS_SHIFT) & sel_rise & r.shreg[CTRL_HI];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_r = r;

    // Two-stage synchronisers for every pin
    next_r.mode_sync     = {r.mode_sync[0], mode_sel};
    next_r.sel_sync      = {r.sel_sync[0], select_n};
    next_r.sck_sync      = {r.sck_sync[0], sck};
    next_r.mosi_sync     = {r.mosi_sync[0], mosi};
    next_r.vdd_sync      = {r.vdd_sync[0], vdd_uv};
    next_r.hv_sync       = {r.hv_sync[0], hv_uv};
    next_r.pump_pin_sync = {r.pump_pin_sync[0], pump_on_pin};
    next_r.flt_pin_sync  = {r.flt_pin_sync[0], fault_shutdown_pin};
    next_r.sel_prev      = sel_n_s;
    next_r.sck_prev      = sck_s;

    // Transaction sequencing
    unique case (r.fsm)
      RFS_IDLE: begin
        if (sel_fall) begin
          // Load held registers and show the MSB at once
          next_r.shreg = {r.driver_control_and_fault, r.switch_path_state};
          next_r.miso  = r.driver_control_and_fault[CTL_WRITE_EN];
          next_r.fsm   = RFS_SHIFT;
        end
      end
      RFS_SHIFT: begin
        if (sel_rise || !serial_mode) begin
          next_r.fsm  = RFS_IDLE;
          next_r.miso = 1'b0;
        end else begin
          // Shift on rise keeps the full frame in place at select rise
          if (sck_rise) begin
            next_r.shreg = {r.shreg[FRAME_BITS-2:0], mosi_s};
          end
          if (sck_fall) begin
            next_r.miso = r.shreg[FRAME_BITS-1];
          end
        end
      end
    endcase

    // Register update at select rise
    if (write_frame) begin
      next_r.switch_path_state = r.shreg[STATE_HI:STATE_LO];
      next_r.driver_control_and_fault = r.shreg[CTRL_HI:CTRL_LO];
      // A write may clear the fault bit but never set it
      next_r.driver_control_and_fault[CTL_FAULT] =
        r.driver_control_and_fault[CTL_FAULT] & r.shreg[CTRL_HI-1];
    end

    // Fault set beats a same-cycle clear and outlives the fault
    if (fault_now) begin
      next_r.driver_control_and_fault[CTL_FAULT] = 1'b1;
    end

    // Shutdown holds until the pump request drops
    if (!pump_req) begin
      next_r.shutdown = 1'b0;
    end
    if (fault_now && !flt_off) begin
      next_r.shutdown = 1'b1;
    end

    // Registered drive outputs
    if (serial_mode && !next_r.shutdown && !sleep_on) begin
      next_r.paths = next_r.switch_path_state[PATH_COUNT-1:0];
    end else begin
      next_r.paths = 4'h0;
    end
    next_r.pump   = pump_req & ~next_r.shutdown & ~sleep_on;
    next_r.analog = ~sleep_on;
    next_r.hv_cmp = ~hv_cmp_off & ~sleep_on;
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Synchronous reset clears both registers and all drive
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r.mode_sync                <= 2'h0;
      r.sel_sync                 <= 2'h3;
      r.sck_sync                 <= 2'h0;
      r.mosi_sync                <= 2'h0;
      r.vdd_sync                 <= 2'h0;
      r.hv_sync                  <= 2'h0;
      r.pump_pin_sync            <= 2'h0;
      r.flt_pin_sync             <= 2'h0;
      r.sel_prev                 <= 1'b1;
      r.sck_prev                 <= 1'b0;
      r.fsm                      <= RFS_IDLE;
      r.shreg                    <= FRAME_RESET;
      r.miso                     <= 1'b0;
      r.switch_path_state        <= STATE_RESET;
      r.driver_control_and_fault <= CTRL_RESET;
      r.shutdown                 <= 1'b0;
      r.paths                    <= 4'h0;
      r.pump                     <= 1'b0;
      r.analog                   <= 1'b0;
      r.hv_cmp                   <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs, all from flip-flops
  // ****************************************************************
  assign miso                         = r.miso;
  assign path1_enable                 = r.paths[0];
  assign path2_enable                 = r.paths[1];
  assign path3_enable                 = r.paths[2];
  assign path4_enable                 = r.paths[3];
  assign pump_enable                  = r.pump;
  assign analog_enable                = r.analog;
  assign hv_comparator_enable         = r.hv_cmp;
  assign fault_latched                = r.driver_control_and_fault[CTL_FAULT];
  assign shutdown_active              = r.shutdown;
  assign switch_path_state_out        = r.switch_path_state;
  assign driver_control_and_fault_out = r.driver_control_and_fault;

endmodule : rfs_serial_ctrl

// >>> test/rfs_host_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Host controller driving the serial port
// ****************************************************************
module rfs_host_model (
  // Clock
  input  wire logic ref_clk,
  // Serial pins
  output logic      select_n,
  output logic      sck,
  output logic      mosi,
  input  wire logic miso
);
  // Idle levels: deselected, clock low, data at pull-down level
  initial begin
    select_n = 1'b1;
    sck      = 1'b0;
    mosi     = 1'b0;
  end
  // Frame of n bits, MSB first; 320 ns clock keeps well under 33 MHz
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = 32'h0000_0000;
    @(posedge ref_clk) select_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = n - 1; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (4) @(posedge ref_clk);
      sck <= 1'b1;
      rx = {rx[30:0], miso};
      repeat (4) @(posedge ref_clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    select_n <= 1'b1;
    mosi     <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : xfer
endmodule : rfs_host_model

// >>> test/rfs_serial_ctrl_asserts.sv
`timescale 1ns/1ns
// ****************************************************************
// Port checker of the serial control block
// ****************************************************************
module rfs_serial_ctrl_asserts (
  // Clock, reset and mode
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       mode_sel,
  // Serial pins and supply monitor
  input  wire logic       select_n,
  input  wire logic       sck,
  input  wire logic       miso,
  input  wire logic       vdd_uv,
  // Drive and status
  input  wire logic       path1_enable,
  input  wire logic       path2_enable,
  input  wire logic       path3_enable,
  input  wire logic       path4_enable,
  input  wire logic       pump_enable,
  input  wire logic       analog_enable,
  input  wire logic       fault_latched,
  input  wire logic       shutdown_active,
  input  wire logic [7:0] switch_path_state_out,
  input  wire logic [7:0] driver_control_and_fault_out
);
  logic [3:0] paths;
  logic [7:0] ctl;
  // Short names for the watched vectors
  assign paths = {path4_enable, path3_enable, path2_enable, path1_enable};
  assign ctl   = driver_control_and_fault_out;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_idle_miso_low: assert property (select_n [*4] |-> !miso)
    else $error("miso not low while deselected");
  a_miso_rise_hold: assert property ($rose(sck) |-> ##2 $stable(miso) [*4])
    else $error("miso moved outside a falling clock edge");
  a_miso_first_msb: assert property ($fell(select_n) && !mode_sel |-> ##[2:3] miso == ctl[7])
    else $error("first miso bit is not the msb");
  a_state_on_select: assert property ($changed(switch_path_state_out) |-> select_n && $past(select_n, 2))
    else $error("switch state changed outside select rise");
  a_ctrl_on_select: assert property ($changed({ctl[7], ctl[5:0]}) |-> select_n && $past(select_n, 2))
    else $error("control changed outside select rise");
  a_fault_clear_write: assert property ($fell(fault_latched) |-> select_n && $past(select_n, 2))
    else $error("fault bit cleared without a write");
  a_fault_rise_set: assert property ($rose(vdd_uv) |-> ##[1:4] fault_latched)
    else $error("fault bit not set after supply fault");
  a_shutdown_cause: assert property ($rose(shutdown_active) |-> fault_latched && !ctl[4])
    else $error("shutdown without fault or while disabled");
  a_shutdown_outs: assert property (shutdown_active [*2] |-> paths == 4'h0 && !pump_enable)
    else $error("outputs on during shutdown");
  a_sleep_outs: assert property (ctl[5] && $past(ctl[5]) |-> !analog_enable && !pump_enable && !path1_enable)
    else $error("analog on during sleep");
  a_path_needs_bit: assert property ((paths & ~(switch_path_state_out[3:0] | $past(switch_path_state_out[3:0]))) == 4'h0)
    else $error("path on without its state bit");
endmodule : rfs_serial_ctrl_asserts

bind rfs_serial_ctrl rfs_serial_ctrl_asserts rfs_serial_ctrl_asserts_i (
  .ref_clk(ref_clk), .rst(rst), .mode_sel(mode_sel), .select_n(select_n), .sck(sck), .miso(miso),
  .vdd_uv(vdd_uv), .path1_enable(path1_enable), .path2_enable(path2_enable), .path3_enable(path3_enable),
  .path4_enable(path4_enable), .pump_enable(pump_enable), .analog_enable(analog_enable),
  .fault_latched(fault_latched), .shutdown_active(shutdown_active),
  .switch_path_state_out(switch_path_state_out), .driver_control_and_fault_out(driver_control_and_fault_out)
);

// >>> test/tb_rfs_serial_ctrl.sv
`timescale 1ns/1ns
// ****************************************************************
// Bench of the serial control block
// ****************************************************************
module tb_rfs_serial_ctrl;
  logic ref_clk = 1'b0, rst = 1'b1, mode_sel = 1'b0, pump_on_pin = 1'b0, fault_shutdown_pin = 1'b0;
  logic vdd_uv = 1'b0, hv_uv = 1'b0, select_n, sck, mosi, miso, p1, p2, p3, p4, pump, analog, hvc, fault, shut;
  logic [7:0] state_out, ctrl_out;
  logic [3:0] paths;
  int err_count = 0, comparisons = 0, cycles = 0;
  assign paths = {p4, p3, p2, p1};
  // 25 MHz reference clock
  always #20 ref_clk = ~ref_clk;
  rfs_host_model rfs_host_model_i (.ref_clk(ref_clk), .select_n(select_n), .sck(sck), .mosi(mosi), .miso(miso));
  rfs_serial_ctrl rfs_serial_ctrl_i (.ref_clk(ref_clk), .rst(rst), .mode_sel(mode_sel), .select_n(select_n),
    .sck(sck), .mosi(mosi), .miso(miso), .pump_on_pin(pump_on_pin), .fault_shutdown_pin(fault_shutdown_pin),
    .vdd_uv(vdd_uv), .hv_uv(hv_uv), .path1_enable(p1), .path2_enable(p2), .path3_enable(p3), .path4_enable(p4),
    .pump_enable(pump), .analog_enable(analog), .hv_comparator_enable(hvc), .fault_latched(fault),
    .shutdown_active(shut), .switch_path_state_out(state_out), .driver_control_and_fault_out(ctrl_out));
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
    logic [31:0] r;
    rfs_host_model_i.xfer({16'h0000, tx}, 16, r);
    rx = r[15:0];
  endtask : frame
  // Short supply dip, long enough for the synchronisers
  task automatic dip(input bit hv);
    @(posedge ref_clk) if (hv) hv_uv <= 1'b1; else vdd_uv <= 1'b1;
    repeat (2) @(posedge ref_clk);
    hv_uv  <= 1'b0;
    vdd_uv <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : dip
  task automatic t_reset();
    logic [15:0] rx;
    frame(16'h0000, rx);
    check("reset frame", 16'h0000, rx);
    check("analog", 16'h0001, {15'h0, analog});
  endtask : t_reset
  // Write, then two read-only frames; the second returns the same data
  task automatic t_write();
    logic [15:0] rx;
    frame(16'h8205, rx);
    check("paths", 16'h0005, {12'h0, paths});
    check("pump", 16'h0001, {15'h0, pump});
    check("ctrl reg", 16'h0082, {8'h00, ctrl_out});
    frame(16'h0000, rx);
    check("readback", 16'h8205, rx);
    frame(16'h00AA, rx);
    check("read only", 16'h8205, rx);
    check("read only state", 16'h0005, {8'h00, state_out});
  endtask : t_write
  // Control bits 0 to 5 alone; pins set high to show they are ignored
  task automatic t_bits();
    logic [15:0] rx;
    pump_on_pin        <= 1'b1;
    fault_shutdown_pin <= 1'b1;
    for (int b = 0; b < 6; b++) begin
      frame({8'h80 | (8'h01 << b), 8'h0F}, rx);
      check("ctrl bit", {9'h0, b != 5, b != 5 && b != 3, b == 1, (b == 5) ? 4'h0 : 4'hF},
            {9'h0, analog, hvc, pump, paths});
    end
    pump_on_pin        <= 1'b0;
    fault_shutdown_pin <= 1'b0;
  endtask : t_bits
  task automatic t_fault();
    logic [15:0] rx;
    frame(16'h8203, rx);
    dip(1'b0);
    check("shutdown", 16'h000C, {12'h0, fault, shut, pump, |paths});
    frame(16'h0000, rx);
    check("fault read", 16'hC203, rx);
    frame(16'h8003, rx);
    frame(16'h8203, rx);
    check("restart", 16'h0007, {11'h0, fault, shut, pump, paths[1:0]});
    // Shutdown disabled: fault is reported but drive stays on
    frame(16'h9203, rx);
    dip(1'b0);
    check("no shutdown", 16'h0017, {11'h0, fault, shut, pump, paths[1:0]});
  endtask : t_fault
  task automatic t_hv();
    logic [15:0] rx;
    frame(16'h880F, rx);
    dip(1'b1);
    check("hv masked", 16'h0000, {15'h0, fault});
    frame(16'h800F, rx);
    dip(1'b1);
    check("hv fault", 16'h0001, {15'h0, fault});
    frame(16'h800F, rx);
    check("hv clear", 16'h0000, {15'h0, fault});
  endtask : t_hv
  // Two frames in one select period, as for a chain of two
  task automatic t_chain();
    logic [31:0] r;
    rfs_host_model_i.xfer(32'h1234_8206, 32, r);
    check("chain old", 16'h800F, r[31:16]);
    check("chain pass", 16'h1234, r[15:0]);
    check("chain load", 16'h0006, {8'h00, state_out});
  endtask : t_chain
  task automatic t_mode();
    logic [15:0] rx;
    mode_sel <= 1'b1;
    repeat (4) @(posedge ref_clk);
    frame(16'h8201, rx);
    check("parallel", 16'h0006, {8'h00, state_out});
    check("parallel miso", 16'h0000, rx);
    mode_sel <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : t_mode
  // Cycle ceiling cuts a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_write();
    t_bits();
    t_fault();
    t_hv();
    t_chain();
    t_mode();
    results();
  end
endmodule : tb_rfs_serial_ctrl
